// ### pkg/sync_sram_consts.svh
// Timing counts, burst geometry and reset values of the burst SRAM control block
`ifndef SYNC_SRAM_CONSTS_SVH
`define SYNC_SRAM_CONSTS_SVH

// Cycles from a raised sleep request to sleep, and from its release to normal operation
`define SSB_SLEEP_ENTER_CYCLES 2
`define SSB_SLEEP_WAKE_CYCLES  2

// Burst counter width, the lane geometry of one stored word and the address width
`define SSB_BURST_W            2
`define SSB_LANE_W             9
`define SSB_LANES              4
`define SSB_ADDR_W             8

// Reset values
`define SSB_RST_BEAT           2'h0
`define SSB_RST_SLEEP_CNT      2'h0

`endif

// ### pkg/sync_sram_pkg.sv
// Types and burst order arithmetic of the burst SRAM control block
package sync_sram_pkg;

    typedef enum logic [1:0] {
        OP_IDLE  = 2'b00,
        OP_READ  = 2'b01,
        OP_WRITE = 2'b10
    } cycle_op_t;

    typedef enum logic [1:0] {
        SL_AWAKE  = 2'b00,
        SL_ENTER  = 2'b01,
        SL_ASLEEP = 2'b10,
        SL_WAKE   = 2'b11
    } sleep_state_t;

    // Low address bits for a given beat of a burst
    function automatic logic [1:0] burst_order(input logic [1:0] start,
                                               input logic [1:0] beat,
                                               input logic       linear_n);
        if (linear_n)
            burst_order = start ^ beat;
        else
            burst_order = 2'(start + beat);
    endfunction

endpackage

// ### hw/burst_addr_gen.sv
// Two-bit burst counter producing the low address bits of each beat
`timescale 1ns/10ps
`include "sync_sram_consts.svh"

module burst_addr_gen
(
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    input  wire logic       i_clk_en,
    input  wire logic       i_load,
    input  wire logic       i_step,
    input  wire logic [1:0] i_start,
    input  wire logic       i_linear_order_n,
    output logic      [1:0] o_low,
    output logic      [1:0] o_start,
    output logic      [1:0] o_beat
);

    logic [1:0] start;
    logic [1:0] beat;
    logic [1:0] next_start;
    logic [1:0] next_beat;

    always_comb
    begin
        next_start = start;
        next_beat  = beat;
        if (i_load)
        begin
            next_start = i_start;
            next_beat  = `SSB_RST_BEAT;
        end
        else if (i_step)
        begin
            // Wraps after four beats, so the fifth repeats the first
            next_beat = 2'(beat + 2'h1);
        end
    end

    // Address used for the cycle now being decoded
    always_comb
    begin
        if (i_load)
            o_low = i_start;
        else
            o_low = sync_sram_pkg::burst_order(start, 2'(beat + 2'h1), i_linear_order_n);
    end

    assign o_start = start;
    assign o_beat  = beat;

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            start <= 2'h0;
            beat  <= `SSB_RST_BEAT;
        end
        else if (i_clk_en)
        begin
            start <= next_start;
            beat  <= next_beat;
        end
    end

endmodule

// ### hw/sync_sram_burst_control.sv
// Synchronous late-write burst SRAM: cycle decode, burst, pipelines, sleep
`timescale 1ns/10ps
`include "sync_sram_consts.svh"


module sync_sram_burst_control #(
    parameter int ADDR_W = `SSB_ADDR_W,
    parameter int LANES  = `SSB_LANES,
    parameter int LANE_W = `SSB_LANE_W
)
(
    input  wire logic                     i_sys_clk,
    input  wire logic                     i_rst,
    input  wire logic                     i_clk_en,
    input  wire logic                     i_load_or_step,
    input  wire logic                     i_write_n,
    input  wire logic [LANES-1:0]         i_lane_write_strobes_n,
    input  wire logic                     i_select_low_first_n,
    input  wire logic                     i_select_high,
    input  wire logic                     i_select_low_third_n,
    input  wire logic                     i_output_enable_n,
    input  wire logic                     i_sleep_request,
    input  wire logic                     i_linear_order_n,
    input  wire logic                     i_pass_through_select_n,
    input  wire logic [ADDR_W-1:0]        i_addr,
    input  wire logic [LANES*LANE_W-1:0]  i_data,
    output logic      [LANES*LANE_W-1:0]  o_data,
    output logic                          o_data_oe_n,
    output logic                          o_asleep
);

    localparam int DATA_W = LANES * LANE_W;
    localparam int DEPTH  = 1 << ADDR_W;

    ////////////////////////////////////////////////////////////////////////////////
    // Sleep sequencing

    sync_sram_pkg::sleep_state_t sleep_state;
    sync_sram_pkg::sleep_state_t next_sleep_state;
    logic [1:0]                  sleep_cnt;
    logic [1:0]                  next_sleep_cnt;

    always_comb
    begin
        next_sleep_state = sleep_state;
        next_sleep_cnt   = sleep_cnt;
        case (sleep_state)
            sync_sram_pkg::SL_AWAKE:
                if (i_sleep_request)
                begin
                    next_sleep_state = sync_sram_pkg::SL_ENTER;
                    next_sleep_cnt   = 2'h1;
                end
            sync_sram_pkg::SL_ENTER:
                if (!i_sleep_request)
                begin
                    next_sleep_state = sync_sram_pkg::SL_AWAKE;
                    next_sleep_cnt   = `SSB_RST_SLEEP_CNT;
                end
                else if (sleep_cnt >= 2'(`SSB_SLEEP_ENTER_CYCLES - 1))
                begin
                    next_sleep_state = sync_sram_pkg::SL_ASLEEP;
                    next_sleep_cnt   = `SSB_RST_SLEEP_CNT;
                end
                else
                    next_sleep_cnt = 2'(sleep_cnt + 2'h1);
            sync_sram_pkg::SL_ASLEEP:
                // Stays asleep for as long as the request is held
                if (!i_sleep_request)
                begin
                    next_sleep_state = sync_sram_pkg::SL_WAKE;
                    next_sleep_cnt   = 2'h1;
                end
            sync_sram_pkg::SL_WAKE:
                if (i_sleep_request)
                begin
                    next_sleep_state = sync_sram_pkg::SL_ASLEEP;
                    next_sleep_cnt   = `SSB_RST_SLEEP_CNT;
                end
                else if (sleep_cnt >= 2'(`SSB_SLEEP_WAKE_CYCLES - 1))
                begin
                    next_sleep_state = sync_sram_pkg::SL_AWAKE;
                    next_sleep_cnt   = `SSB_RST_SLEEP_CNT;
                end
                else
                    next_sleep_cnt = 2'(sleep_cnt + 2'h1);
            default:
            begin
                next_sleep_state = sync_sram_pkg::SL_AWAKE;
                next_sleep_cnt   = `SSB_RST_SLEEP_CNT;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sleep_state <= sync_sram_pkg::SL_AWAKE;
            sleep_cnt   <= `SSB_RST_SLEEP_CNT;
        end
        else if (i_clk_en)
        begin
            sleep_state <= next_sleep_state;
            sleep_cnt   <= next_sleep_cnt;
        end
    end

    wire logic asleep = (sleep_state == sync_sram_pkg::SL_ASLEEP);
    assign o_asleep = asleep;

    ////////////////////////////////////////////////////////////////////////////////
    // Cycle decode and burst

    // A floating pass-through pin is pulled high by the pad, so anything but low is pipeline
    wire logic pipeline = (i_pass_through_select_n != 1'b0);
    wire logic selected = !i_select_low_first_n && i_select_high && !i_select_low_third_n;

    sync_sram_pkg::cycle_op_t burst_op;
    sync_sram_pkg::cycle_op_t next_burst_op;
    sync_sram_pkg::cycle_op_t cur_op;
    logic [ADDR_W-1:0]        burst_hi;
    logic [ADDR_W-1:0]        next_burst_hi;
    logic [1:0]               cur_low;
    logic [1:0]               burst_start;
    logic [1:0]               burst_beat;
    logic                     do_load;
    logic                     do_step;

    always_comb
    begin
        next_burst_op = burst_op;
        next_burst_hi = burst_hi;
        cur_op        = sync_sram_pkg::OP_IDLE;
        do_load       = 1'b0;
        do_step       = 1'b0;
        if (asleep)
            cur_op = sync_sram_pkg::OP_IDLE;
        else if (!i_load_or_step)
        begin
            do_load       = 1'b1;
            next_burst_hi = i_addr;
            if (!selected)
                next_burst_op = sync_sram_pkg::OP_IDLE;
            else if (i_write_n)
                next_burst_op = sync_sram_pkg::OP_READ;
            else if (&i_lane_write_strobes_n)
                next_burst_op = sync_sram_pkg::OP_IDLE;
            else
                next_burst_op = sync_sram_pkg::OP_WRITE;
            cur_op = next_burst_op;
        end
        else
        begin
            // Write and selects are not looked at; a deselect just carries on
            do_step = 1'b1;
            cur_op  = burst_op;
        end
        // Writes arriving while recovering from sleep are dropped
        if (sleep_state == sync_sram_pkg::SL_WAKE && cur_op == sync_sram_pkg::OP_WRITE)
            cur_op = sync_sram_pkg::OP_IDLE;
    end

    burst_addr_gen u_burst
    (
        .i_sys_clk        (i_sys_clk),
        .i_rst            (i_rst),
        .i_clk_en         (i_clk_en),
        .i_load           (do_load),
        .i_step           (do_step),
        .i_start          (i_addr[1:0]),
        .i_linear_order_n (i_linear_order_n),
        .o_low            (cur_low),
        .o_start          (burst_start),
        .o_beat           (burst_beat)
    );

    wire logic [ADDR_W-1:0] cur_addr = {burst_hi[ADDR_W-1:2], cur_low};
    wire logic [ADDR_W-1:0] dec_addr = do_load ? i_addr : cur_addr;

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            burst_op <= sync_sram_pkg::OP_IDLE;
            burst_hi <= '0;
        end
        else if (i_clk_en)
        begin
            burst_op <= next_burst_op;
            burst_hi <= next_burst_hi;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Data pipelines and memory

    logic [DATA_W-1:0] mem [DEPTH];

    sync_sram_pkg::cycle_op_t s1_op;
    sync_sram_pkg::cycle_op_t s2_op;
    logic [ADDR_W-1:0]        s1_addr;
    logic [ADDR_W-1:0]        s2_addr;
    logic [LANES-1:0]         s1_strobes_n;
    logic [LANES-1:0]         s2_strobes_n;
    logic [DATA_W-1:0]        dout;
    logic                     dout_valid;
    logic [DATA_W-1:0]        next_dout;
    logic                     next_dout_valid;

    // Lane merge shared by the array write and the read bypass
    function automatic logic [DATA_W-1:0] merge_lanes(input logic [DATA_W-1:0] old_word,
                                                      input logic [DATA_W-1:0] new_word,
                                                      input logic [LANES-1:0]  strobes_n);
        logic [DATA_W-1:0] word;
        word = old_word;
        for (int l = 0; l < LANES; l++)
            if (!strobes_n[l])
                word[l*LANE_W +: LANE_W] = new_word[l*LANE_W +: LANE_W];
        return word;
    endfunction

    // Flow-through writes take data one edge late, pipeline writes two
    wire logic wr_now = pipeline ? (s2_op == sync_sram_pkg::OP_WRITE)
                                 : (s1_op == sync_sram_pkg::OP_WRITE);
    wire logic [ADDR_W-1:0] wr_addr    = pipeline ? s2_addr : s1_addr;
    wire logic [LANES-1:0]  wr_strobes = pipeline ? s2_strobes_n : s1_strobes_n;

    // Flow-through loads the output register at the address edge, pipeline one edge later
    wire logic rd_now = pipeline ? (s1_op == sync_sram_pkg::OP_READ)
                                 : (cur_op == sync_sram_pkg::OP_READ);
    wire logic [ADDR_W-1:0] rd_addr = pipeline ? s1_addr : dec_addr;

    always_comb
    begin
        next_dout       = dout;
        next_dout_valid = rd_now;
        if (rd_now)
        begin
            // A write landing on the same edge must be visible to the read
            if (wr_now && wr_addr == rd_addr)
                next_dout = merge_lanes(mem[rd_addr], i_data, wr_strobes);
            else
                next_dout = mem[rd_addr];
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_clk_en && wr_now)
            mem[wr_addr] <= merge_lanes(mem[wr_addr], i_data, wr_strobes);
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            s1_op        <= sync_sram_pkg::OP_IDLE;
            s2_op        <= sync_sram_pkg::OP_IDLE;
            s1_addr      <= '0;
            s2_addr      <= '0;
            s1_strobes_n <= '1;
            s2_strobes_n <= '1;
            dout         <= '0;
            dout_valid   <= 1'b0;
        end
        else if (i_clk_en)
        begin
            s1_op        <= cur_op;
            s2_op        <= s1_op;
            s1_addr      <= dec_addr;
            s2_addr      <= s1_addr;
            s1_strobes_n <= i_lane_write_strobes_n;
            s2_strobes_n <= s1_strobes_n;
            dout         <= next_dout;
            dout_valid   <= next_dout_valid;
        end
    end

    assign o_data = dout;
    // Output enable and sleep request gate the drivers without waiting for a clock
    assign o_data_oe_n = !(dout_valid && !i_output_enable_n && !i_sleep_request && !asleep);

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    power_up_hiz_a: assert property (@(posedge i_sys_clk) $fell(i_rst) |-> o_data_oe_n)
        else $error("data pins driven right after reset");

    begin_read_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_clk_en && !i_load_or_step && i_write_n && selected && !asleep)
        |=> (s1_op == sync_sram_pkg::OP_READ && s1_addr == $past(i_addr)))
        else $error("selected load did not start a read");

    continue_op_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_clk_en && i_load_or_step && sleep_state == sync_sram_pkg::SL_AWAKE)
        |=> (s1_op == $past(burst_op)))
        else $error("continue cycle changed operation");

    linear_step_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_clk_en && i_load_or_step && !i_linear_order_n && !asleep)
        |=> (s1_addr[1:0] == 2'($past(burst_start) + $past(burst_beat) + 2'h1)))
        else $error("linear burst address wrong");

    interleave_step_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_clk_en && i_load_or_step && i_linear_order_n && !asleep)
        |=> (s1_addr[1:0] == ($past(burst_start) ^ 2'($past(burst_beat) + 2'h1))))
        else $error("interleaved burst address wrong");

    burst_wrap_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_clk_en && !i_load_or_step && !asleep) ##1 (i_clk_en && i_load_or_step)[*4]
        |=> (s1_addr == $past(s1_addr, 4)))
        else $error("fifth burst address does not repeat the first");

    deselect_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_clk_en && !i_load_or_step && !selected) ##1 (i_clk_en && i_load_or_step)
        |=> (s1_op == sync_sram_pkg::OP_IDLE && o_data_oe_n))
        else $error("deselect or its continuation did not idle");

    dummy_read_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_output_enable_n || i_sleep_request) |-> o_data_oe_n)
        else $error("pins driven with output disabled");

    write_hiz_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (!pipeline && s1_op == sync_sram_pkg::OP_WRITE) |-> o_data_oe_n)
        else $error("drivers on during write");

    stall_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !i_clk_en |=> ($stable(s1_addr) && $stable(dout) && $stable(dout_valid)
                       && $stable(sleep_state)))
        else $error("state moved while clock enable low");

    sleep_entry_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (sleep_state == sync_sram_pkg::SL_AWAKE && i_sleep_request && i_clk_en)
        ##1 (i_sleep_request && i_clk_en) |=> asleep)
        else $error("sleep not entered after two cycles");

    wake_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (asleep && !i_sleep_request && i_clk_en) ##1 (!i_sleep_request && i_clk_en)
        |=> (sleep_state == sync_sram_pkg::SL_AWAKE))
        else $error("wake not complete after two cycles");

    asleep_idle_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (asleep && i_clk_en) |=> (s1_op == sync_sram_pkg::OP_IDLE))
        else $error("operation accepted while asleep");

    read_cover_c: cover property (@(posedge i_sys_clk) disable iff (i_rst)
        (s1_op == sync_sram_pkg::OP_READ) ##1 !o_data_oe_n);
    write_burst_c: cover property (@(posedge i_sys_clk) disable iff (i_rst)
        (s1_op == sync_sram_pkg::OP_WRITE) ##1 (s1_op == sync_sram_pkg::OP_WRITE)[*3]);
    sleep_cycle_c: cover property (@(posedge i_sys_clk) disable iff (i_rst)
        asleep ##1 (sleep_state == sync_sram_pkg::SL_WAKE));

endmodule

// ### dv/mem_ctrl_model.sv
// Memory controller model driving the command, mode and write data pins of the SRAM block
`timescale 1ns/10ps

module mem_ctrl_model
(
    input  wire logic   i_sys_clk,
    output logic        o_ce  = 1'b1,
    output logic        o_ls  = 1'b0,
    output logic        o_wn  = 1'b1,
    output logic [3:0]  o_st  = 4'hF,
    output logic        o_s1n = 1'b1,
    output logic        o_s2  = 1'b0,
    output logic        o_s3n = 1'b1,
    output logic        o_oen = 1'b0,
    output logic        o_slp = 1'b0,
    output logic        o_lin = 1'b0,
    output logic        o_ftn = 1'b1,
    output logic [7:0]  o_a   = 8'h00,
    output logic [35:0] o_d   = 36'h0_0000_0000
);
    // Write data waits here: two beats late when pipelined, one when flowing
    logic [35:0] p1  = 36'h0_0000_0000;
    logic [35:0] p2  = 36'h0_0000_0000;
    int          way = 0;

    ////////////////////////////////////////////////////////////////////////////
    task automatic step(input logic ls, wn, input logic [3:0] st, input logic sel,
                        input logic [7:0] a, input logic [35:0] wd);
        @(posedge i_sys_clk);
        o_ce  <= 1'b1;
        o_ls  <= ls;
        o_wn  <= wn;
        o_st  <= st;
        // Deselects rotate over the three selects so each one is exercised
        o_s1n <= !sel && way == 0;
        o_s2  <= sel || way != 1;
        o_s3n <= !sel && way == 2;
        way   = sel ? way : (way + 1) % 3;
        o_a   <= a;
        o_d   <= o_ftn ? p2 : p1;
        p2    = p1;
        p1    = wd;
    endtask

    task automatic stall(input int n);
        repeat (n)
        begin
            @(posedge i_sys_clk);
            o_ce <= 1'b0;
        end
    endtask

    // Only raised from an idle bus, since work in flight may be lost
    task automatic set_sleep(input logic v);
        @(posedge i_sys_clk);
        o_slp <= v;
    endtask

    task automatic set_pins(input logic oen, lin, ftn);
        o_oen = oen;
        o_lin = lin;
        o_ftn = ftn;
    endtask
endmodule

// ### dv/testbench.sv
// Self-checking bench for the burst SRAM control block
`timescale 1ns/10ps

module testbench;
    logic        i_sys_clk = 1'b0;
    logic        i_rst     = 1'b1;
    logic        ce, ls, wn, s1n, s2, s3n, oen, slp, lin, ftn, doe_n, asleep;
    logic [3:0]  st;
    logic [7:0]  a;
    logic [35:0] wd, rd;
    logic [35:0] mem [256];
    logic [36:0] e1 = 37'h0, e2 = 37'h0, el;
    int          num_errors = 0;
    int          n_compared = 0;

    initial
    begin
        forever #12.5 i_sys_clk = !i_sys_clk;
    end

    mem_ctrl_model ctrl_u (.i_sys_clk(i_sys_clk), .o_ce(ce), .o_ls(ls), .o_wn(wn), .o_st(st),
        .o_s1n(s1n), .o_s2(s2), .o_s3n(s3n), .o_oen(oen), .o_slp(slp), .o_lin(lin),
        .o_ftn(ftn), .o_a(a), .o_d(wd));

    sync_sram_burst_control dut_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clk_en(ce),
        .i_load_or_step(ls), .i_write_n(wn), .i_lane_write_strobes_n(st),
        .i_select_low_first_n(s1n), .i_select_high(s2), .i_select_low_third_n(s3n),
        .i_output_enable_n(oen), .i_sleep_request(slp), .i_linear_order_n(lin),
        .i_pass_through_select_n(ftn), .i_addr(a), .i_data(wd), .o_data(rd),
        .o_data_oe_n(doe_n), .o_asleep(asleep));

    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("errors %0d, comparisons %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [35:0] seen, exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [35:0] pat(input logic [7:0] x);
        pat = {x, 1'b1, ~x, 1'b0, x ^ 8'h5A, 1'b1, ~x ^ 8'h3C, 1'b0};
    endfunction

    // One command; judges the output that the command one or two beats back left
    task automatic cyc(input logic l, w, input logic [3:0] s, input logic sel,
                       input logic [7:0] x, input logic [35:0] d, input int kind);
        logic [36:0] e;
        e = {kind == 1, kind == 1 ? mem[x] : 36'h0_0000_0000};
        if (kind == 2)
            for (int k = 0; k < 4; k++)
                if (!s[k]) mem[x][k*9 +: 9] = d[k*9 +: 9];
        ctrl_u.step(l, w, s, sel, x, d);
        #1;
        el = ftn ? e2 : e1;
        e2 = e1;
        e1 = e;
        check({35'h0, doe_n}, {35'h0, !(el[36] && !oen && !slp)});
        if (el[36] && !oen) check(rd, el[35:0]);
    endtask

    // A deselect, then deselect-continue beats that carry a write pattern
    task automatic idle(input int n);
        cyc(1'b0, 1'b1, 4'hF, 1'b0, 8'h00, pat(8'(n_compared)), 0);
        repeat (n - 1) cyc(1'b1, 1'b0, 4'h0, 1'b0, 8'h00, pat(8'(n)), 0);
    endtask

    task automatic burst(input logic ln, w, input logic [7:0] base, input int beats);
        logic [7:0] x;
        // Read the model's own pins: a mode just set in this time step may not have reached the nets
        ctrl_u.set_pins(ctrl_u.o_oen, ln, ctrl_u.o_ftn);
        for (int b = 0; b < beats; b++)
        begin
            x = {base[7:2], ln ? base[1:0] ^ 2'(b) : 2'(base[1:0] + 2'(b))};
            // Continue beats deselect, flip the store strobe and pull all lanes low
            if (b == 0) cyc(1'b0, !w, w ? 4'h0 : 4'hF, 1'b1, x, pat(x), w ? 2 : 1);
            else cyc(1'b1, w, 4'h0, 1'b0, x, pat(x), w ? 2 : 1);
        end
        idle(2);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_lanes;
        burst(1'b0, 1'b1, 8'h44, 4);
        cyc(1'b0, 1'b0, 4'b1010, 1'b1, 8'h44, 36'h1_2345_6789, 2);
        cyc(1'b0, 1'b0, 4'hF, 1'b1, 8'h45, 36'h0_0000_0000, 0);
        cyc(1'b0, 1'b0, 4'b0101, 1'b1, 8'h46, 36'hA_BCDE_F012, 2);
        cyc(1'b1, 1'b1, 4'hF, 1'b0, 8'h47, 36'h5_5555_5555, 2);
        idle(2);
        burst(1'b0, 1'b0, 8'h44, 4);
    endtask

    task automatic t_stall;
        // Stall while the first beat of a read stands on the pins
        cyc(1'b0, 1'b1, 4'hF, 1'b1, 8'h44, 36'h0_0000_0000, 1);
        cyc(1'b1, 1'b1, 4'hF, 1'b0, 8'h45, 36'h0_0000_0000, 1);
        ctrl_u.stall(2);
        #1;
        check({35'h0, doe_n}, 36'h0_0000_0000);
        check(rd, mem[8'h44]);
        idle(3);
    endtask

    task automatic t_dummy;
        ctrl_u.set_pins(1'b1, 1'b0, ftn);
        burst(1'b0, 1'b0, 8'h12, 1);
        ctrl_u.set_pins(1'b0, 1'b0, ftn);
        #1;
        check({35'h0, doe_n}, 36'h0_0000_0000);
        check(rd, mem[8'h12]);
        idle(2);
    endtask

    task automatic t_sleep;
        int n;
        ctrl_u.set_sleep(1'b1);
        #1;
        check({35'h0, doe_n}, 36'h1);
        // Look just after each edge, once the sleep state has settled
        for (n = 0; asleep !== 1'b1 && n < 6; n++) @(posedge i_sys_clk) #1;
        check(36'(n), 36'h2);
        cyc(1'b0, 1'b0, 4'h0, 1'b1, 8'h44, 36'h0_0000_0000, 0);
        cyc(1'b1, 1'b1, 4'h0, 1'b0, 8'h45, 36'h0_0000_0000, 0);
        idle(2);
        ctrl_u.set_sleep(1'b0);
        for (n = 0; asleep !== 1'b0 && n < 6; n++) @(posedge i_sys_clk) #1;
        check(36'(n <= 2), 36'h1);
        idle(2);
        burst(1'b0, 1'b0, 8'h44, 4);
    endtask

    task automatic t_flow;
        ctrl_u.set_pins(1'b0, 1'b0, 1'b0);
        burst(1'b0, 1'b1, 8'h80, 4);
        burst(1'b1, 1'b0, 8'h82, 5);
    endtask

    initial
    begin
        repeat (4000) @(posedge i_sys_clk);
        num_errors++;
        complete_run();
    end

    initial
    begin
        repeat (3) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        #1;
        check({35'h0, doe_n}, 36'h1);
        check({35'h0, asleep}, 36'h0);
        idle(2);
        burst(1'b0, 1'b1, 8'h11, 4);
        burst(1'b0, 1'b0, 8'h11, 5);
        burst(1'b0, 1'b1, 8'h60, 4);
        burst(1'b1, 1'b0, 8'h63, 5);
        t_lanes();
        t_stall();
        t_dummy();
        t_sleep();
        t_flow();
        complete_run();
    end
endmodule
